// file: core/ssb_pkg.sv
// constants, types and decode tables for the subtract/shift/bank/stop group
// assumes one core clock and a synchronous active-high reset
// Behaviour
// - bank zero select, 4F, 1 byte 4 cycles, clears bank bit, no flags
// - bank one select, 5F, 1 byte 4 cycles, sets bank bit, no flags
// - subtract with borrow stores dst minus src minus carry via complement add
// - borrow subtract opcodes 32-36; 2B/4, 2B/6, 3B/6 cycle forms
// - borrow subtract: carry on borrow, zero on zero, sign on negative
// - borrow subtract overflow: opposite operand signs, result sign equals source
// - both subtracts set decimal-adjust; half-carry clear on bit 3 carry
// - carry force, DF, 1 byte 4 cycles, sets carry only
// - arithmetic right shift keeps bit 7, bit 0 to carry, D0/D1
// - shift flags: carry from bit 0, zero, sign, overflow cleared
// - pointer load, 31, selects pointers by src bits 1..0; one takes bits 7..3
// - both pointers take src 7..4; bit 3 is 0 and 1 respectively
// - pointers read at D6h and D7h; loading 40h gives 40h and 48h
// - halt, 7F, 1 byte 4 cycles, stops clocks, registers retained
// - stopped mode left only by reset or external interrupt; no flags
// - plain subtract stores dst minus src, opcodes 22-26, same forms
// - plain subtract flags: carry borrow, zero, sign, overflow as borrow form
package ssb_pkg;
  localparam logic [7:0] OP_BANK_ZERO = 8'h4f;
  localparam logic [7:0] OP_BANK_ONE = 8'h5f;
  localparam logic [7:0] OP_SUBB_LO = 8'h32;
  localparam logic [7:0] OP_SUBB_HI = 8'h36;
  localparam logic [7:0] OP_SUB_LO = 8'h22;
  localparam logic [7:0] OP_SUB_HI = 8'h26;
  localparam logic [7:0] OP_CARRY_FORCE = 8'hdf;
  localparam logic [7:0] OP_ASR_REG = 8'hd0;
  localparam logic [7:0] OP_ASR_IND = 8'hd1;
  localparam logic [7:0] OP_PTR_LOAD = 8'h31;
  localparam logic [7:0] OP_HALT = 8'h7f;
  // low opcode nibble of the two-operand forms
  localparam logic [3:0] FORM_RR = 4'h2;
  localparam logic [3:0] FORM_RIR = 4'h3;
  // condition word bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam int FLAG_BANK = 0;
  localparam logic [7:0] COND_RESET = 8'h00;
  // pointer locations and reset values
  localparam logic [7:0] PTR0_ADDR = 8'hd6;
  localparam logic [7:0] PTR1_ADDR = 8'hd7;
  localparam logic [7:0] PTR0_RESET = 8'h00;
  localparam logic [7:0] PTR1_RESET = 8'h08;
  localparam logic [1:0] SEL_BOTH = 2'b00;
  localparam logic [1:0] SEL_ZERO = 2'b10;
  localparam logic [1:0] SEL_ONE = 2'b01;
  // timing counts in core cycles, and byte lengths
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  typedef enum logic [3:0] {
    K_BANK_ZERO, K_BANK_ONE, K_SUBB, K_SUB, K_CFORCE, K_ASR, K_PTR, K_HALT, K_BAD
  } ssb_kind_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dst;
    logic [7:0] src;
  } ssb_insn_s;

  typedef struct packed {
    logic [7:0] value;
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } ssb_alu_s;

  function automatic ssb_kind_e ssb_kind(input logic [7:0] opc);
    ssb_kind_e k;
    k = K_BAD;
    if (opc == OP_BANK_ZERO) k = K_BANK_ZERO;
    if (opc == OP_BANK_ONE) k = K_BANK_ONE;
    if (opc >= OP_SUBB_LO && opc <= OP_SUBB_HI) k = K_SUBB;
    if (opc >= OP_SUB_LO && opc <= OP_SUB_HI) k = K_SUB;
    if (opc == OP_CARRY_FORCE) k = K_CFORCE;
    if (opc == OP_ASR_REG || opc == OP_ASR_IND) k = K_ASR;
    if (opc == OP_PTR_LOAD) k = K_PTR;
    if (opc == OP_HALT) k = K_HALT;
    return k;
  endfunction

  // two-operand forms: r,r short; r,@r long; full-address forms long and 3 bytes
  function automatic logic [2:0] ssb_cycles(input logic [7:0] opc);
    ssb_kind_e k;
    k = ssb_kind(opc);
    if ((k == K_SUBB || k == K_SUB) && opc[3:0] != FORM_RR) return CYC_LONG;
    return CYC_SHORT;
  endfunction

  function automatic logic [1:0] ssb_bytes(input logic [7:0] opc);
    ssb_kind_e k;
    k = ssb_kind(opc);
    if (k == K_SUBB || k == K_SUB)
      return (opc[3:0] > FORM_RIR) ? LEN_THREE : LEN_TWO;
    if (k == K_ASR || k == K_PTR) return LEN_TWO;
    return LEN_ONE;
  endfunction
endpackage

// file: core/ssb_sub_shift_alu.sv
// subtract and arithmetic right shift datapath with flag results
// assumes operands are held stable by the caller; purely combinational
`timescale 1ns/10ps
module ssb_sub_shift_alu (
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic carry_in,
  input wire logic use_borrow,
  input wire logic shift_sel,
  output ssb_pkg::ssb_alu_s res
);
  import ssb_pkg::*;

  // subtraction as dst + ~src + 1, minus the borrow when asked
  always_comb begin
    logic [8:0] sum;
    logic [4:0] low;
    logic cin;
    sum = 9'h000;
    low = 5'h00;
    cin = use_borrow ? ~carry_in : 1'b1;
    sum = {1'b0, dst} + {1'b0, ~src} + {8'h00, cin};
    low = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + {4'h0, cin};
    res = '0;
    if (shift_sel) begin
      res.value = {dst[7], dst[7:1]};
      res.c = dst[0];
      res.v = 1'b0;
    end else begin
      res.value = sum[7:0];
      res.c = ~sum[8]; // no carry out means a borrow
      res.v = (dst[7] != src[7]) && (sum[7] == src[7]);
      res.d = 1'b1;
      res.h = ~low[4];
    end
    res.z = (res.value == 8'h00);
    res.s = res.value[7];
  end
endmodule

// file: core/ssb_exec_unit.sv
// execution unit for bank select, subtracts, carry force, arithmetic shift,
// pointer load and clock-stop entry; owns the condition word and pointers
// assumes the core fetches operands and writes dst_result back itself
`timescale 1ns/10ps
module ssb_exec_unit (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic issue,
  input ssb_pkg::ssb_insn_s insn,
  input wire logic ext_wake,
  input wire logic [7:0] reg_addr,
  output logic busy,
  output logic done,
  output logic bad_op,
  output logic [1:0] insn_bytes,
  output logic [7:0] dst_result,
  output logic dst_we,
  output logic [7:0] cond_word,
  output logic [7:0] ptr_zero,
  output logic [7:0] ptr_one,
  output logic [7:0] reg_rdata,
  output logic stopped
);
  import ssb_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_STOP = 2'b11
  } ssb_state_e;

  ssb_state_e state;
  ssb_insn_s cur;
  ssb_kind_e kind;
  logic [2:0] cnt;
  logic [2:0] wake_ff;
  logic wake_lvl;
  ssb_alu_s alu;
  logic take;
  logic finish;

  assign take = issue && state == ST_IDLE;
  assign finish = state == ST_RUN && cnt == 3'h0;

  ssb_sub_shift_alu u_alu (
    .dst(cur.dst),
    .src(cur.src),
    .carry_in(cond_word[FLAG_C]),
    .use_borrow(kind == K_SUBB),
    .shift_sel(kind == K_ASR),
    .res(alu)
  );

  // interrupt pin: three stages, level changes once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_ff <= 3'h0;
      wake_lvl <= 1'b0;
    end else begin
      wake_ff <= {wake_ff[1:0], ext_wake};
      if (wake_ff[1] == wake_ff[2]) wake_lvl <= wake_ff[2];
    end
  end

  // sequencing: an instruction owns the unit for its full cycle count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      cur <= '0;
      kind <= K_BAD;
      insn_bytes <= 2'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (issue) begin
            cur <= insn;
            kind <= ssb_kind(insn.opcode);
            insn_bytes <= ssb_bytes(insn.opcode);
            cnt <= 3'(ssb_cycles(insn.opcode) - 3'h2);
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
          end else begin
            state <= (kind == K_HALT) ? ST_STOP : ST_IDLE;
          end
        end
        ST_STOP: begin
          // only the interrupt pin or reset leaves; state elsewhere is kept
          if (wake_lvl) state <= ST_IDLE;
        end
      endcase
    end
  end

  // status outputs follow the sequencer one edge behind its decision
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      bad_op <= 1'b0;
      stopped <= 1'b0;
    end else begin
      busy <= take || (state == ST_RUN && !finish);
      done <= finish;
      bad_op <= finish && kind == K_BAD;
      if (finish && kind == K_HALT) begin
        stopped <= 1'b1; // core and system clocks gated by this level
      end else if (state == ST_STOP && wake_lvl) begin
        stopped <= 1'b0;
      end
    end
  end

  // destination write-back for the operations that produce a byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dst_result <= 8'h00;
      dst_we <= 1'b0;
    end else begin
      dst_we <= finish && (kind == K_SUBB || kind == K_SUB || kind == K_ASR);
      if (finish) dst_result <= alu.value;
    end
  end

  // condition word: each kind touches only its own bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cond_word <= COND_RESET;
    end else if (finish) begin
      unique case (kind)
        K_BANK_ZERO: cond_word[FLAG_BANK] <= 1'b0;
        K_BANK_ONE: cond_word[FLAG_BANK] <= 1'b1;
        K_CFORCE: cond_word[FLAG_C] <= 1'b1;
        K_SUBB, K_SUB: begin
          cond_word[FLAG_C] <= alu.c;
          cond_word[FLAG_Z] <= alu.z;
          cond_word[FLAG_S] <= alu.s;
          cond_word[FLAG_V] <= alu.v;
          cond_word[FLAG_D] <= alu.d;
          cond_word[FLAG_H] <= alu.h;
        end
        K_ASR: begin
          cond_word[FLAG_C] <= alu.c;
          cond_word[FLAG_Z] <= alu.z;
          cond_word[FLAG_S] <= alu.s;
          cond_word[FLAG_V] <= 1'b0;
        end
        K_PTR, K_HALT, K_BAD: ;
      endcase
    end
  end

  // window pointers; select 11 writes nothing, an unused encoding
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ptr_zero <= PTR0_RESET;
      ptr_one <= PTR1_RESET;
    end else if (finish && kind == K_PTR) begin
      unique case (cur.src[1:0])
        SEL_ZERO: ptr_zero[7:3] <= cur.src[7:3];
        SEL_ONE: ptr_one[7:3] <= cur.src[7:3];
        SEL_BOTH: begin
          ptr_zero[7:3] <= {cur.src[7:4], 1'b0};
          ptr_one[7:3] <= {cur.src[7:4], 1'b1};
        end
        default: ;
      endcase
    end
  end

  // register-file view of the pointers; other addresses read zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= (reg_addr == PTR0_ADDR) ? ptr_zero :
                   (reg_addr == PTR1_ADDR) ? ptr_one : 8'h00;
    end
  end

  // checks on the observable behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_bank_zero_clear: assert property (
    take && insn.opcode == OP_BANK_ZERO |-> ##4 (done && !cond_word[FLAG_BANK]
      && cond_word[7:1] == $past(cond_word[7:1])))
    else $error("bank zero select did not clear bank bit in 4 cycles");

  a_bank_one_set: assert property (
    take && insn.opcode == OP_BANK_ONE |-> ##4 (done && cond_word[FLAG_BANK]
      && cond_word[7:1] == $past(cond_word[7:1])))
    else $error("bank one select did not set bank bit in 4 cycles");

  a_subb_value: assert property (
    done && kind == K_SUBB |->
      dst_we && dst_result == 8'(cur.dst - cur.src - {7'h00, $past(cond_word[FLAG_C])}))
    else $error("borrow subtract stored a wrong difference");

  a_sub_long_timing: assert property (
    take && ssb_kind(insn.opcode) inside {K_SUBB, K_SUB} && insn.opcode[3:0] != FORM_RR
      |=> !done [*5] ##1 done)
    else $error("long subtract form did not take 6 cycles");

  a_sub_short_timing: assert property (
    take && ssb_kind(insn.opcode) inside {K_SUBB, K_SUB} && insn.opcode[3:0] == FORM_RR
      |-> ##4 (done && insn_bytes == LEN_TWO))
    else $error("register subtract form did not take 4 cycles");

  a_subb_carry: assert property (
    done && kind == K_SUBB |-> cond_word[FLAG_C] ==
      ({1'b0, cur.src} + {8'h00, $past(cond_word[FLAG_C])} > {1'b0, cur.dst})
      && cond_word[FLAG_Z] == (dst_result == 8'h00))
    else $error("borrow subtract carry or zero wrong");

  a_subb_overflow: assert property (
    done && kind == K_SUBB |-> cond_word[FLAG_V] ==
      ((cur.dst[7] != cur.src[7]) && (dst_result[7] == cur.src[7])))
    else $error("borrow subtract overflow wrong");

  a_sub_dec_half: assert property (
    done && kind inside {K_SUBB, K_SUB} |-> cond_word[FLAG_D]
      && cond_word[FLAG_H] == ({1'b0, cur.src[3:0]} > {1'b0, cur.dst[3:0]}
      || (kind == K_SUBB && $past(cond_word[FLAG_C]) && cur.src[3:0] == cur.dst[3:0])))
    else $error("decimal-adjust or half-carry wrong after subtract");

  a_carry_force: assert property (
    done && kind == K_CFORCE |-> cond_word[FLAG_C]
      && cond_word[6:0] == $past(cond_word[6:0]))
    else $error("carry force changed other bits or left carry clear");

  a_asr_shape: assert property (
    done && kind == K_ASR |-> dst_we && dst_result == {cur.dst[7], cur.dst[7:1]}
      && insn_bytes == LEN_TWO)
    else $error("arithmetic shift result wrong");

  a_asr_flags: assert property (
    done && kind == K_ASR |-> cond_word[FLAG_C] == cur.dst[0] && !cond_word[FLAG_V]
      && cond_word[FLAG_S] == dst_result[7]
      && cond_word[3:0] == $past(cond_word[3:0]))
    else $error("arithmetic shift flags wrong");

  a_ptr_single: assert property (
    done && kind == K_PTR && cur.src[1:0] == SEL_ZERO |->
      ptr_zero[7:3] == cur.src[7:3] && ptr_one == $past(ptr_one))
    else $error("single pointer load wrong");

  a_ptr_both: assert property (
    done && kind == K_PTR && cur.src[1:0] == SEL_BOTH |->
      ptr_zero[7:3] == {cur.src[7:4], 1'b0} && ptr_one[7:3] == {cur.src[7:4], 1'b1}
      && cond_word == $past(cond_word))
    else $error("dual pointer load wrong");

  a_ptr_one_only: assert property (
    done && kind == K_PTR && cur.src[1:0] == SEL_ONE |->
      ptr_one[7:3] == cur.src[7:3] && ptr_zero == $past(ptr_zero))
    else $error("pointer one load touched pointer zero");

  a_ptr_readback: assert property (
    reg_addr == PTR1_ADDR |=> reg_rdata == $past(ptr_one))
    else $error("pointer one not visible at its location");

  a_halt_entry: assert property (
    take && insn.opcode == OP_HALT |-> ##4 (done && stopped
      && cond_word == $past(cond_word)))
    else $error("halt did not stop after 4 cycles");

  a_stop_hold: assert property (
    stopped && !wake_lvl |=> stopped && !done && !busy)
    else $error("stopped mode left without a wake");

  a_sub_flags: assert property (
    done && kind == K_SUB |-> dst_result == 8'(cur.dst - cur.src)
      && cond_word[FLAG_C] == (cur.src > cur.dst) && cond_word[FLAG_V] ==
      ((cur.dst[7] != cur.src[7]) && (dst_result[7] == cur.src[7])))
    else $error("plain subtract result or flags wrong");

  // one-cycle strobes, shift zero flag, pointer zero view and wake release
  a_done_single: assert property (
    done |=> !done && !dst_we)
    else $error("done or write strobe stood longer than one cycle");

  a_asr_zero: assert property (
    done && kind == K_ASR |-> cond_word[FLAG_Z] == (dst_result == 8'h00))
    else $error("arithmetic shift zero flag wrong");

  a_ptr_zero_readback: assert property (
    reg_addr == PTR0_ADDR |=> reg_rdata == $past(ptr_zero))
    else $error("pointer zero not visible at its location");

  a_wake_release: assert property (
    stopped && wake_lvl |=> !stopped && !busy)
    else $error("stopped mode kept after a wake");

  c_subb_done: cover property (done && kind == K_SUBB && cond_word[FLAG_V]);
  c_back_to_back: cover property (done && take);
  c_halt_wake: cover property (stopped ##[1:50] !stopped);
  c_ptr_both: cover property (done && kind == K_PTR && cur.src[1:0] == SEL_BOTH);
  c_asr_neg: cover property (done && kind == K_ASR && dst_result[7]);
endmodule

// file: sim/testbench.sv
// self-checking bench for the subtract/shift/bank/stop execution unit
// assumes done shows N-1 edges after the take edge, as the unit's hand-over says
`timescale 1ns/10ps
module testbench;
  import ssb_pkg::*;
  logic clk_sys;
  logic reset;
  logic issue;
  ssb_insn_s insn;
  logic ext_wake;
  logic [7:0] reg_addr;
  logic busy, done, bad_op, dst_we, stopped;
  logic [1:0] insn_bytes;
  logic [7:0] dst_result, cond_word, ptr_zero, ptr_one, reg_rdata;
  logic [7:0] exp_cond;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  ssb_exec_unit ssb_exec_unit_inst (
    .clk_sys(clk_sys), .reset(reset), .issue(issue), .insn(insn), .ext_wake(ext_wake),
    .reg_addr(reg_addr), .busy(busy), .done(done), .bad_op(bad_op),
    .insn_bytes(insn_bytes), .dst_result(dst_result), .dst_we(dst_we),
    .cond_word(cond_word), .ptr_zero(ptr_zero), .ptr_one(ptr_one),
    .reg_rdata(reg_rdata), .stopped(stopped)
  );

  // 40 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset;
    reset = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    exp_cond = 8'h00;
  endtask

  // one instruction: held until the take edge, then timed to done
  task automatic exec(input logic [7:0] opc, input logic [7:0] d, input logic [7:0] s,
      input int n, input logic [1:0] nb, input logic we, input logic [7:0] res,
      input logic bad);
    int cnt;
    insn.opcode = opc;
    insn.dst = d;
    insn.src = s;
    issue = 1'b1;
    @(posedge clk_sys);
    #1;
    issue = 1'b0;
    cnt = 0;
    chk({7'h0, busy}, 8'h01, "busy after take");
    while (done !== 1'b1 && cnt < 20) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    chk(8'(cnt), 8'(n - 1), "cycles to done");
    chk({6'h0, insn_bytes}, {6'h0, nb}, "byte length");
    chk({7'h0, dst_we}, {7'h0, we}, "write strobe");
    chk({7'h0, bad_op}, {7'h0, bad}, "unknown opcode flag");
    if (we) chk(dst_result, res, "result");
    chk(cond_word, exp_cond, "condition word");
  endtask

  // expected flags worked out from the operands; carry-in only for the 3x forms
  task automatic do_sub(input logic [7:0] opc, input logic [7:0] d, input logic [7:0] s);
    logic cin;
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] r;
    cin = (opc[7:4] == 4'h3) ? exp_cond[FLAG_C] : 1'b0;
    full = {1'b0, d} - {1'b0, s} - 9'(cin);
    low = {1'b0, d[3:0]} - {1'b0, s[3:0]} - 5'(cin);
    r = full[7:0];
    exp_cond[FLAG_C] = full[8];
    exp_cond[FLAG_Z] = (r == 8'h00);
    exp_cond[FLAG_S] = r[7];
    exp_cond[FLAG_V] = (d[7] != s[7]) && (r[7] == s[7]);
    exp_cond[FLAG_D] = 1'b1;
    exp_cond[FLAG_H] = low[4];
    exec(opc, d, s, (opc[3:0] == 4'h2) ? 4 : 6, (opc[3:0] > 4'h3) ? 2'h3 : 2'h2, 1'b1, r, 1'b0);
  endtask

  task automatic t_reset_values;
    chk({busy, done, bad_op, dst_we, stopped, 3'h0}, 8'h00, "reset strobes");
    chk({6'h0, insn_bytes}, 8'h00, "reset byte length");
    chk(cond_word, 8'h00, "reset condition word");
    chk(ptr_zero, 8'h00, "reset pointer zero");
    chk(ptr_one, 8'h08, "reset pointer one");
  endtask

  // bank bit set first, so every later flag check also proves it is preserved
  task automatic t_bank_carry;
    exp_cond[FLAG_BANK] = 1'b1;
    exec(8'h5f, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b0);
    exp_cond[FLAG_C] = 1'b1;
    exec(8'hdf, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b0);
    exec(8'hdf, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b0);
  endtask

  task automatic t_subtracts;
    logic [7:0] dv[5] = '{8'h12, 8'h21, 8'h21, 8'h10, 8'h80};
    logic [7:0] sv[5] = '{8'h03, 8'h90, 8'h65, 8'h10, 8'h01};
    for (int i = 0; i < 5; i++) begin
      do_sub(8'h22 + 8'(i), dv[i], sv[i]);
    end
    exp_cond[FLAG_C] = 1'b1;
    exec(8'hdf, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b0);
    for (int i = 0; i < 5; i++) begin
      do_sub(8'h32 + 8'(i), dv[i], sv[i]);
    end
  endtask

  task automatic t_shift;
    logic [7:0] dv[4] = '{8'h9a, 8'hbc, 8'h01, 8'h7f};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      r = {dv[i][7], dv[i][7:1]};
      exp_cond[FLAG_C] = dv[i][0];
      exp_cond[FLAG_Z] = (r == 8'h00);
      exp_cond[FLAG_S] = r[7];
      exp_cond[FLAG_V] = 1'b0;
      exec(8'hd0 + 8'(i % 2), dv[i], 8'h00, 4, 2'h2, 1'b1, r, 1'b0);
    end
  endtask

  task automatic readback(input logic [7:0] addr, input logic [7:0] exp);
    reg_addr = addr;
    @(posedge clk_sys);
    #1;
    chk(reg_rdata, exp, "pointer readback");
  endtask

  // select codes 00, 10, 01 and the unused 11 that loads nothing
  task automatic t_pointers;
    logic [7:0] sv[4] = '{8'h40, 8'h52, 8'h69, 8'h73};
    logic [7:0] e0[4] = '{8'h40, 8'h50, 8'h50, 8'h50};
    logic [7:0] e1[4] = '{8'h48, 8'h48, 8'h68, 8'h68};
    for (int i = 0; i < 4; i++) begin
      exec(8'h31, 8'h00, sv[i], 4, 2'h2, 1'b0, 8'h00, 1'b0);
      chk(ptr_zero, e0[i], "pointer zero");
      chk(ptr_one, e1[i], "pointer one");
      readback(8'hd6, e0[i]);
      readback(8'hd7, e1[i]);
    end
    readback(8'hd5, 8'h00);
  endtask

  task automatic t_bad_and_first_bank;
    exec(8'h00, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b1);
    exp_cond[FLAG_BANK] = 1'b0;
    exec(8'h4f, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b0);
  endtask

  // stop, refuse work while stopped, wake by interrupt, then stop and leave by reset
  task automatic t_stop;
    int seen;
    int cnt;
    exec(8'h7f, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b0);
    chk({7'h0, stopped}, 8'h01, "stopped entered");
    insn.opcode = 8'h22;
    insn.dst = 8'h05;
    insn.src = 8'h01;
    issue = 1'b1;
    seen = 0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (done === 1'b1 || dst_we === 1'b1) seen++;
    end
    issue = 1'b0;
    chk(8'(seen), 8'h00, "work while stopped");
    chk({7'h0, stopped}, 8'h01, "still stopped");
    ext_wake = 1'b1;
    cnt = 0;
    while (stopped !== 1'b0 && cnt < 12) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    ext_wake = 1'b0;
    chk({7'h0, stopped}, 8'h00, "woken by interrupt");
    chk(cond_word, exp_cond, "flags kept over stop");
    chk(ptr_one, 8'h68, "pointer kept over stop");
    exp_cond[FLAG_C] = 1'b1;
    exec(8'hdf, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b0);
    exec(8'h7f, 8'h00, 8'h00, 4, 2'h1, 1'b0, 8'h00, 1'b0);
    // outside reset held well past any settling interval
    do_reset();
    chk({7'h0, stopped}, 8'h00, "left by reset");
  endtask

  initial begin
    issue = 1'b0;
    insn = '0;
    ext_wake = 1'b0;
    reg_addr = 8'h00;
    exp_cond = 8'h00;
    do_reset();
    t_reset_values();
    t_bank_carry();
    t_subtracts();
    t_shift();
    t_pointers();
    t_bad_and_first_bank();
    t_stop();
    report_and_stop();
  end
endmodule
